// [rtl/ptm_pkg.sv]
// Holds the constants, control-field layout and carriers of the paired timer.
// Assumes one 100 MHz clock; all pins arrive synchronous to it.
//
// Contract
// - Two 16-bit timers, joinable into one 32-bit.
// - Independent timers support all synchronous 16-bit modes.
// - Joined pair is a 32-bit timer or sync counter.
// - Lower timer is low half, upper high half.
// - Joined mode ignores the upper control entirely.
// - Joined mode clocks and gates from lower inputs.
// - Joined period match raises the upper flag.
// - Joined interrupt on full 32-bit period match.
// - Period is upper half over lower half.
// - Count reads as upper half over lower half.
// - Converter trigger comes only from joined timer.
// - Each timer exports a time base for capture/compare.
// - Each timer counts internal or external clock.
// - Gating, prescale, keeps running in idle/sleep.
// - Lower run bit starts pair or lower only.
// - Prescale code 11 divides 256, 10 divides 64.
// - Idle-stop bit halts timer during device idle.
package ptm_pkg;
  // ==========================================================
  // Widths and prescale codes
  localparam int PTM_HALF_W = 16;
  localparam logic [1:0] PTM_PS_DIV1 = 2'h0;
  localparam logic [1:0] PTM_PS_DIV8 = 2'h1;
  localparam logic [1:0] PTM_PS_DIV64 = 2'h2;
  localparam logic [1:0] PTM_PS_DIV256 = 2'h3;
  // Prescale terminal counts (ratio minus one)
  localparam logic [7:0] PTM_TC_DIV8 = 8'h07;
  localparam logic [7:0] PTM_TC_DIV64 = 8'h3f;
  localparam logic [7:0] PTM_TC_DIV256 = 8'hff;
  localparam logic [7:0] PTM_PS_ZERO = 8'h00;
  localparam logic [15:0] PTM_CNT_ZERO = 16'h0000;
  localparam logic [15:0] PTM_CNT_ONE = 16'h0001;

  // ==========================================================
  // Control fields of one timer
  typedef struct packed {
    logic timerRun;             // Run bit
    logic idleStopSelect;       // Halt in idle when set
    logic gateAccumulateEnable; // Gated accumulation
    logic [1:0] prescaleSelect; // Prescale code
    logic pairJoinSelect;       // Join pair (lower only)
    logic clockSourceSelect;    // 1 = external pin
  } ptm_ctrl_s;

  // Clock and gate inputs of one timer
  typedef struct packed {
    logic extClk;  // External clock pin level
    logic gate;    // Gate pin level
  } ptm_pins_s;

  // One timer's state
  typedef struct packed {
    logic [7:0] psCnt;   // Prescale counter
    logic [15:0] count;  // Running count
    logic extPrev;       // Last ext clock level
    logic gatePrev;      // Last gate level
  } ptm_core_s;
endpackage

// [rtl/ptm_core.sv]
// Holds one 16-bit timing core: prescaler, edge detect, gate, period match.
// Assumes ext clock and gate pins already synchronous to sys_clk.
`timescale 1ns/100ps
module ptm_core (
  input wire logic sys_clk,
  input wire logic rst,
  input ptm_pkg::ptm_ctrl_s ctrl,
  input ptm_pkg::ptm_pins_s pins,
  input wire logic idleMode,
  input wire logic cntEn,
  input wire logic clearCount,
  input wire logic [15:0] period,
  output logic tick,
  output logic [15:0] countQ,
  output logic match,
  output logic gateFall
);
  import ptm_pkg::*;

  // ==========================================================
  // State
  ptm_core_s st_q;
  ptm_core_s st_d;
  logic [7:0] psTc;
  logic srcEdge;
  logic running;

  // Prescale terminal count decode
  function automatic logic [7:0] tcOf(input logic [1:0] code);
    case (code)
      PTM_PS_DIV8: tcOf = PTM_TC_DIV8;
      PTM_PS_DIV64: tcOf = PTM_TC_DIV64;
      PTM_PS_DIV256: tcOf = PTM_TC_DIV256;
      default: tcOf = PTM_PS_ZERO;
    endcase
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    st_d = st_q;
    psTc = tcOf(ctrl.prescaleSelect);
    st_d.extPrev = pins.extClk;
    st_d.gatePrev = pins.gate;
    // Rising ext edge or every internal cycle
    // Ext edge is taken on sys_clk only, so no async counting
    srcEdge = ctrl.clockSourceSelect ? (pins.extClk & ~st_q.extPrev) : 1'b1;
    // Gate only applies to the internal clock
    running = cntEn & ~(idleMode & ctrl.idleStopSelect);
    if (!ctrl.clockSourceSelect && ctrl.gateAccumulateEnable) begin
      running = running & pins.gate;
    end
    tick = 1'b0;
    if (running && srcEdge) begin
      if (st_q.psCnt >= psTc) begin
        st_d.psCnt = PTM_PS_ZERO;
        tick = 1'b1;
      end else begin
        st_d.psCnt = st_q.psCnt + 8'h01;
      end
    end
    // Stopped timer restarts prescale from scratch
    if (!cntEn) begin
      st_d.psCnt = PTM_PS_ZERO;
    end
    // Count clear is decided by the parent, on the 32-bit match in joined mode
    if (clearCount) begin
      st_d.count = PTM_CNT_ZERO;
    end else if (tick) begin
      st_d.count = st_q.count + PTM_CNT_ONE;
    end
  end

  // Registered state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign countQ = st_q.count;
  assign match = (st_q.count == period);
  // Gate fall flagged only in gated internal mode, while enabled
  assign gateFall = cntEn & ~ctrl.clockSourceSelect & ctrl.gateAccumulateEnable
                    & st_q.gatePrev & ~pins.gate;
endmodule

// [rtl/ptm_paired_timer.sv]
// Holds the paired 16/32-bit timer top: two cores, join logic, flags.
// Assumes control bits come from a register file outside; flags are
// pulses cleared by the caller's own flag logic.
`timescale 1ns/100ps
module ptm_paired_timer (
  input wire logic sys_clk,
  input wire logic rst,
  input ptm_pkg::ptm_ctrl_s lowerTimerControl,
  input ptm_pkg::ptm_ctrl_s upperTimerControl,
  input ptm_pkg::ptm_pins_s lowerPins,
  input ptm_pkg::ptm_pins_s upperPins,
  input wire logic idleMode,
  input wire logic [15:0] periodLow,
  input wire logic [15:0] periodHigh,
  output logic [15:0] countLow,
  output logic [15:0] countHigh,
  output logic lowerIrqPulse,
  output logic upperIrqPulse,
  output logic converterTrigger,
  output logic lowerTimeBaseTick,
  output logic upperTimeBaseTick
);
  import ptm_pkg::*;

  // ==========================================================
  // Output state, all registered
  typedef struct packed {
    logic lowIrq;
    logic upIrq;
    logic trig;
    logic lowTb;
    logic upTb;
  } ptm_out_s;

  ptm_out_s st_q;
  ptm_out_s st_d;
  logic joined;
  ptm_ctrl_s upCtrl;
  ptm_pins_s upPins;
  logic upEn;
  logic lowEn;
  logic lowTick;
  logic upTick;
  logic lowMatch;
  logic upMatch;
  logic lowFall;
  logic upFall;
  logic fullMatch;
  logic lowClr;
  logic upClr;
  logic [15:0] upCount;
  logic [15:0] lowCount;
  logic joinHighMatch; // Joined high half equals its period half

  // ==========================================================
  // Join steering: upper core borrows lower control and pins
  assign joined = lowerTimerControl.pairJoinSelect;
  assign upCtrl = joined ? lowerTimerControl : upperTimerControl;
  assign upPins = joined ? lowerPins : upperPins;
  assign lowEn = lowerTimerControl.timerRun;
  // Upper stays put while joined; lower tick drives both halves
  assign upEn = joined ? 1'b0 : upperTimerControl.timerRun;
  // Joined high half lives in the carry flop, not in the idle upper core
  assign fullMatch = lowMatch & (joined ? joinHighMatch : upMatch);
  // Clear on match at the next counting tick
  assign lowClr = lowTick & (joined ? fullMatch : lowMatch);
  assign upClr = joined ? (lowTick & fullMatch) : (upTick & upMatch);

  ptm_core u_low (
    .sys_clk(sys_clk),
    .rst(rst),
    .ctrl(lowerTimerControl),
    .pins(lowerPins),
    .idleMode(idleMode),
    .cntEn(lowEn),
    .clearCount(lowClr),
    .period(periodLow),
    .tick(lowTick),
    .countQ(lowCount),
    .match(lowMatch),
    .gateFall(lowFall)
  );

  // Upper core; in joined mode its count is carried in below
  logic [15:0] carryCount_q;
  ptm_core u_up (
    .sys_clk(sys_clk),
    .rst(rst),
    .ctrl(upCtrl),
    .pins(upPins),
    .idleMode(idleMode),
    .cntEn(upEn),
    .clearCount(upClr),
    .period(periodHigh),
    .tick(upTick),
    .countQ(upCount),
    .match(upMatch),
    .gateFall(upFall)
  );

  // ==========================================================
  // High half in joined mode: carry from the lower half
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      carryCount_q <= PTM_CNT_ZERO;
    end else if (!joined) begin
      carryCount_q <= PTM_CNT_ZERO;
    end else if (lowClr) begin
      carryCount_q <= PTM_CNT_ZERO;
    end else if (lowTick && lowCount == {PTM_HALF_W{1'b1}}) begin
      carryCount_q <= carryCount_q + PTM_CNT_ONE;
    end
  end

  // ==========================================================
  // Flag and trigger next state
  always_comb begin
    st_d = st_q;
    if (joined) begin
      st_d.lowIrq = 1'b0;
      st_d.upIrq = lowClr | lowFall;
      st_d.trig = lowClr;
      st_d.lowTb = lowTick;
      st_d.upTb = lowTick;
    end else begin
      st_d.lowIrq = lowClr | lowFall;
      st_d.upIrq = upClr | upFall;
      st_d.trig = 1'b0;
      st_d.lowTb = lowTick;
      st_d.upTb = upTick;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Count pair readout
  assign countLow = lowCount;
  assign countHigh = joined ? carryCount_q : upCount;
  // Match uses the joined high half when joined
  assign joinHighMatch = (carryCount_q == periodHigh);
  assign lowerIrqPulse = st_q.lowIrq;
  assign upperIrqPulse = st_q.upIrq;
  assign converterTrigger = st_q.trig;
  assign lowerTimeBaseTick = st_q.lowTb;
  assign upperTimeBaseTick = st_q.upTb;

  // ==========================================================
  // Checks
  a_joined_trig: assert property (@(posedge sys_clk) disable iff (rst)
    converterTrigger |-> $past(joined)) else $error("trigger when not joined");
  a_lower_silent: assert property (@(posedge sys_clk) disable iff (rst)
    $past(joined) |-> !lowerIrqPulse) else $error("lower irq in joined");
  a_run_stops: assert property (@(posedge sys_clk) disable iff (rst)
    !lowEn ##1 !lowEn |-> $stable(countLow)) else $error("count while stopped");
  a_idle_halt: assert property (@(posedge sys_clk) disable iff (rst)
    idleMode && lowerTimerControl.idleStopSelect ##1 idleMode
    && lowerTimerControl.idleStopSelect && $stable(lowerTimerControl)
    |-> $stable(countLow)) else $error("count in idle stop");
  a_wrap_zero: assert property (@(posedge sys_clk) disable iff (rst)
    !joined && lowTick && lowMatch |=> countLow == PTM_CNT_ZERO)
    else $error("no wrap on match");
  a_irq_match: assert property (@(posedge sys_clk) disable iff (rst)
    !joined && lowTick && lowMatch ##1 !joined |-> lowerIrqPulse)
    else $error("match without flag");
  a_gate_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !lowerTimerControl.clockSourceSelect && lowerTimerControl.gateAccumulateEnable
    && !lowerPins.gate |-> !lowTick) else $error("tick with gate low");
  a_full_match: assert property (@(posedge sys_clk) disable iff (rst)
    joined && lowTick && lowMatch && joinHighMatch ##1 joined |-> upperIrqPulse)
    else $error("32-bit match missed");
  a_upper_ignored: assert property (@(posedge sys_clk) disable iff (rst)
    joined |-> !upTick) else $error("upper ran while joined");
  a_div1_tick: assert property (@(posedge sys_clk) disable iff (rst)
    lowEn && !idleMode && lowerTimerControl.prescaleSelect == PTM_PS_DIV1
    && !lowerTimerControl.clockSourceSelect && !lowerTimerControl.gateAccumulateEnable
    |-> lowTick) else $error("div1 missing tick");
  c_joined_trig: cover property (@(posedge sys_clk) disable iff (rst) converterTrigger);
  c_upper_irq: cover property (@(posedge sys_clk) disable iff (rst) upperIrqPulse && !joined);
  c_gate_fall: cover property (@(posedge sys_clk) disable iff (rst) lowFall);
endmodule

// [dv/ptm_pin_model.sv]
// Partner model: drives the lower timer's external clock and gate pins.
// Assumes bench commands arrive by non-blocking assignment at a rising edge.
`timescale 1ns/100ps
module ptm_pin_model (
  input wire logic sys_clk,
  input wire logic startReq,
  input wire logic [7:0] edgeCount,
  input wire logic gateLevel,
  output ptm_pkg::ptm_pins_s pins
);
  import ptm_pkg::*;
  // =====
  // Burst generator
  logic [9:0] leftQ = '0; // Cycles left in a burst, four per edge
  logic clkQ = 1'b0; // Pin level, low outside a burst
  // Two cycles high, two low, so each edge is seen by a sampling core
  always @(posedge sys_clk) begin
    if (startReq) begin
      leftQ <= {edgeCount, 2'b00};
    end else if (leftQ != 10'h000) begin
      leftQ <= leftQ - 10'h001;
    end
    clkQ <= (leftQ != 10'h000) && leftQ[1];
  end
  // Gate follows the bench's request directly
  assign pins = '{extClk: clkQ, gate: gateLevel};
endmodule

// [dv/test_paired_timer_16_32.sv]
// Bench of the paired 16/32-bit timer: scenario tasks and a verdict.
// Assumes the pin model above; upper pins stay tied low.
`timescale 1ns/100ps
module test_paired_timer_16_32;
  import ptm_pkg::*;
  // =====
  // Stimulus and observed signals
  logic sys_clk, rst, idleMode, startReq, gateLevel;
  logic [7:0] edgeCount;
  ptm_ctrl_s loCtl, hiCtl;
  ptm_pins_s loPins;
  logic [15:0] periodLow, periodHigh, countLow, countHigh;
  logic loIrq, hiIrq, convTrig, loTick, hiTick;
  logic [4:0] outs; // Pulses gathered for the wait task
  logic [31:0] prevCnt; // Count one cycle before a pulse
  int fail_count = 0;
  int checks_done = 0;
  int nLo, nConv; // Event counters
  int n;
  assign outs = {convTrig, hiIrq, loIrq, hiTick, loTick};
  ptm_paired_timer u_dut (.sys_clk(sys_clk), .rst(rst), .lowerTimerControl(loCtl),
    .upperTimerControl(hiCtl), .lowerPins(loPins), .upperPins('0), .idleMode(idleMode),
    .periodLow(periodLow), .periodHigh(periodHigh), .countLow(countLow),
    .countHigh(countHigh), .lowerIrqPulse(loIrq), .upperIrqPulse(hiIrq),
    .converterTrigger(convTrig), .lowerTimeBaseTick(loTick), .upperTimeBaseTick(hiTick));
  ptm_pin_model u_pins (.sys_clk(sys_clk), .startReq(startReq), .edgeCount(edgeCount),
    .gateLevel(gateLevel), .pins(loPins));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Counts pulses that a scenario must see or must not see
  // Cleared by each reset so one process alone drives them
  always @(posedge sys_clk) begin
    if (rst) begin
      nLo <= 0;
      nConv <= 0;
    end else begin
      nLo <= nLo + int'(loIrq === 1'b1);
      nConv <= nConv + int'(convTrig === 1'b1);
    end
  end
  // =====
  // Shared tasks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic ptm_ctrl_s mk(input logic [1:0] ps, input logic jn, input logic src,
    input logic gt, input logic stp);
    return '{timerRun: 1'b0, idleStopSelect: stp, gateAccumulateEnable: gt,
      prescaleSelect: ps, pairJoinSelect: jn, clockSourceSelect: src};
  endfunction
  // Reset held six cycles, which clears the counters, then one more edge
  task automatic reset_all();
    rst <= 1'b1;
    loCtl <= '0;
    hiCtl <= '0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Setup first, run bit on the following edge
  task automatic start_lo(input ptm_ctrl_s c);
    loCtl <= c;
    @(posedge sys_clk);
    loCtl.timerRun <= 1'b1;
  endtask
  // Bounded wait for one pulse bit; n counts edges waited
  task automatic wait_bit(input int b, input int limit);
    n = 0;
    do begin
      prevCnt = {countHigh, countLow};
      @(posedge sys_clk);
      #1;
      n++;
    end while (outs[b] !== 1'b1 && n < limit);
  endtask
  // =====
  // Scenarios
  task automatic t_indep();
    reset_all();
    periodLow <= 16'h0004;
    periodHigh <= 16'h0002;
    hiCtl <= mk(2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    @(posedge sys_clk);
    hiCtl.timerRun <= 1'b1;
    start_lo(mk(2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
    wait_bit(2, 20);
    wait_bit(2, 20);
    check("lower span", 32'h5, n);
    check("lower at match", 32'h4, prevCnt[15:0]);
    wait_bit(3, 20);
    wait_bit(3, 20);
    check("upper span", 32'h3, n);
    check("no trigger", 32'h0, nConv);
    $display("test independent done");
  endtask
  task automatic t_prescale();
    int ratio [4] = '{1, 8, 64, 256};
    for (int c = 0; c < 4; c++) begin
      reset_all();
      periodLow <= 16'hffff;
      start_lo(mk(c[1:0], 1'b0, 1'b0, 1'b0, 1'b0));
      wait_bit(0, 600);
      wait_bit(0, 600);
      check("tick span", ratio[c], n);
    end
    $display("test prescale done");
  endtask
  task automatic t_joined();
    reset_all();
    periodLow <= 16'h0000;
    periodHigh <= 16'h0001;
    hiCtl <= '{timerRun: 1'b0, idleStopSelect: 1'b1, gateAccumulateEnable: 1'b1,
      prescaleSelect: 2'h3, pairJoinSelect: 1'b0, clockSourceSelect: 1'b1};
    start_lo(mk(2'h0, 1'b1, 1'b0, 1'b0, 1'b0));
    wait_bit(3, 70000);
    check("joined at match", 32'h00010000, prevCnt);
    check("joined wrap", 32'h0, {countHigh, countLow});
    check("upper flag", 32'h1, hiIrq);
    check("lower flag quiet", 32'h0, nLo);
    check("trigger", 32'h1, convTrig);
    check("upper time base", 32'h1, hiTick);
    $display("test joined done");
  endtask
  task automatic t_pins();
    logic [15:0] snap;
    reset_all();
    periodLow <= 16'hffff;
    start_lo(mk(2'h0, 1'b0, 1'b1, 1'b0, 1'b1));
    startReq <= 1'b1;
    @(posedge sys_clk);
    startReq <= 1'b0;
    repeat (30) @(posedge sys_clk);
    check("ext count", 32'h5, countLow);
    loCtl <= mk(2'h0, 1'b0, 1'b0, 1'b1, 1'b1);
    idleMode <= 1'b1;
    @(posedge sys_clk);
    loCtl.timerRun <= 1'b1;
    repeat (3) @(posedge sys_clk);
    snap = countLow;
    gateLevel <= 1'b1;
    repeat (10) @(posedge sys_clk);
    check("idle hold", snap, countLow);
    idleMode <= 1'b0;
    repeat (10) @(posedge sys_clk);
    gateLevel <= 1'b0;
    wait_bit(2, 4);
    check("gate fall flag", 32'h1, loIrq);
    snap = countLow;
    repeat (5) @(posedge sys_clk);
    check("gate low hold", snap, countLow);
    $display("test pins done");
  endtask
  // =====
  // Verdict and main sequence
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    idleMode = 1'b0;
    startReq = 1'b0;
    gateLevel = 1'b0;
    edgeCount = 8'h05;
    loCtl = '0;
    hiCtl = '0;
    periodLow = '0;
    periodHigh = '0;
    t_indep();
    t_prescale();
    t_joined();
    t_pins();
    tally_and_finish();
  end
  // Run needs about 66000 cycles; cut off at 90000
  initial begin
    #900000;
    fail_count++;
    tally_and_finish();
  end
endmodule
